// ---- hw/rrmc_pkg.sv ----
// constants and types for the radio reset and mode control block
// Function
// - reset on power-up, glitch or software command
// - ignore serial commands during power-up reset
// - two reset modes, sensitive by default
// - normal mode disables supply glitch reset
// - mode command bit zero selects normal mode
// - command word FE00h starts software reset
// - software reset like power-up, 0.25ms long
// - software reset acts only in sensitive mode
// - every reset returns mode to sensitive
// - reset sets status flag, drives interrupt low
// - status read clears flag, releases interrupt
package rrmc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POR_TIME_NS = 100000000;
  localparam int unsigned SOFT_TIME_NS = 250000;
  // longest times round down
  localparam int unsigned POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SOFT_CYCLES = SOFT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 23;

  // serial command words
  localparam int unsigned CMD_W = 16;
  localparam logic [15:0] SOFT_RESTART_CMD = 16'hFE00;
  localparam logic [15:0] STATUS_READ_MASK = 16'h8000;
  localparam logic [15:0] STATUS_READ_CODE = 16'h0000;
  localparam logic [7:0] FIFO_MODE_OPCODE = 8'hC0;
  localparam int unsigned OPCODE_LSB = 8;
  localparam int unsigned MODE_BIT = 0;
  localparam logic [3:0] LAST_BIT = 4'hF;

  // synchroniser lanes
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned SY_RAMP = 0;
  localparam int unsigned SY_GLITCH = 1;
  localparam int unsigned SY_SEL = 2;
  localparam int unsigned SY_VALID = 3;

  typedef enum logic [2:0] {
    RRMC_RUN  = 3'b001,
    RRMC_PWR  = 3'b010,
    RRMC_SOFT = 3'b100
  } rrmc_state_t;

endpackage : rrmc_pkg

// ---- hw/rrmc_link.sv ----
// serial link receiver on the controller's shift clock
`timescale 1ns/1ps
module rrmc_link
  import rrmc_pkg::*;
(
  input wire logic sck,
  input wire logic sel_b,
  input wire logic sdi,
  output logic [rrmc_pkg::CMD_W-1:0] word_q,
  output logic valid_q
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [CMD_W-1:0] sh;
    logic [CMD_W-1:0] word;
    logic valid;
  } rrmc_link_st_t;

  rrmc_link_st_t q, d;

  always_comb
  begin
    d = q;
    // bits past the first word are dropped until the frame ends
    if (!q.valid)
    begin
      d.sh = {q.sh[CMD_W-2:0], sdi};
      d.cnt = q.cnt + 4'h1;
      if (q.cnt == LAST_BIT)
      begin
        d.word = {q.sh[CMD_W-2:0], sdi};
        d.valid = 1'b1;
      end
    end
  end

  // the clock stops outside frames, so the frame end itself clears the state
  always_ff @(posedge sck or posedge sel_b)
  begin
    if (sel_b)
      q <= '0;
    else
      q <= d;
  end

  assign word_q = q.word;
  assign valid_q = q.valid;

endmodule : rrmc_link

// ---- hw/rrmc_top.sv ----
// reset cause gathering, reset mode selection and command lockout
`timescale 1ns/1ps
module rrmc_top
  import rrmc_pkg::*;
#(
  parameter logic [rrmc_pkg::CNT_W-1:0] POR_LEN = rrmc_pkg::CNT_W'(rrmc_pkg::POR_CYCLES),
  parameter logic [rrmc_pkg::CNT_W-1:0] SOFT_LEN = rrmc_pkg::CNT_W'(rrmc_pkg::SOFT_CYCLES)
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic supply_ramp,
  input wire logic vdd_glitch,
  input wire logic sck,
  input wire logic sel_b,
  input wire logic sdi,
  output logic reset_active,
  output logic sensitive_mode,
  output logic por_status,
  output logic interrupt_request_low,
  output logic cmd_taken
);

  import rrmc_pkg::*;

  typedef struct packed {
    rrmc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic valid_p;
    logic frame_bad;
    logic mode_normal;
    logic por_flag;
    logic taken;
  } rrmc_top_st_t;

  rrmc_top_st_t q, d;
  logic [CMD_W-1:0] link_word;
  logic link_valid;
  logic in_reset;
  logic word_rise;
  logic cmd_fire;
  logic is_status;
  logic is_soft;
  logic is_mode;
  logic glitch_hit;

  rrmc_link u_link (
    .sck(sck),
    .sel_b(sel_b),
    .sdi(sdi),
    .word_q(link_word),
    .valid_q(link_valid)
  );

  always_comb
  begin
    d = q;
    in_reset = (q.state != RRMC_RUN);
    d.s1 = {link_valid, sel_b, vdd_glitch, supply_ramp};
    d.s2 = q.s1;
    d.valid_p = q.s2[SY_VALID];
    word_rise = q.s2[SY_VALID] & ~q.valid_p;
    // a frame touched by reset stays tainted until the select goes high
    if (in_reset && !q.s2[SY_SEL])
      d.frame_bad = 1'b1;
    else if (q.s2[SY_SEL])
      d.frame_bad = 1'b0;
    // word is stable by the time its valid level is seen here
    cmd_fire = word_rise & ~in_reset & ~q.frame_bad;
    is_status = (link_word & STATUS_READ_MASK) == STATUS_READ_CODE;
    is_soft = link_word == SOFT_RESTART_CMD;
    is_mode = link_word[CMD_W-1:OPCODE_LSB] == FIFO_MODE_OPCODE;
    glitch_hit = q.s2[SY_GLITCH] & ~q.mode_normal;
    d.taken = cmd_fire;
    if (cmd_fire && is_status)
      d.por_flag = 1'b0;
    if (cmd_fire && is_mode)
      d.mode_normal = link_word[MODE_BIT];
    d.cnt = (q.cnt != '0) ? q.cnt - CNT_W'(1) : q.cnt;
    case (q.state)
      RRMC_RUN:
      begin
        if (q.s2[SY_RAMP] || glitch_hit)
        begin
          d.state = RRMC_PWR;
          d.cnt = POR_LEN - CNT_W'(1);
        end
        else if (cmd_fire && is_soft && !q.mode_normal)
        begin
          d.state = RRMC_SOFT;
          d.cnt = SOFT_LEN - CNT_W'(1);
        end
      end
      RRMC_PWR:
      begin
        // supply still low holds the reset; the count, running since entry, sets its shortest length
        if (q.cnt == '0 && !q.s2[SY_RAMP])
          d.state = RRMC_RUN;
      end
      RRMC_SOFT:
      begin
        if (q.s2[SY_RAMP] || glitch_hit)
        begin
          d.state = RRMC_PWR;
          d.cnt = POR_LEN - CNT_W'(1);
        end
        else if (q.cnt == '0)
          d.state = RRMC_RUN;
      end
      default:
      begin
        d.state = RRMC_PWR;
        d.cnt = POR_LEN - CNT_W'(1);
      end
    endcase
    if (d.state != RRMC_RUN)
    begin
      d.mode_normal = 1'b0;
      d.por_flag = 1'b1;
    end
  end

  // reset puts the device straight into a power-up period
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      q.state <= RRMC_PWR;
      q.cnt <= POR_LEN - CNT_W'(1);
      q.s1 <= '0;
      q.s2 <= '0;
      q.valid_p <= 1'b0;
      q.frame_bad <= 1'b0;
      q.mode_normal <= 1'b0;
      q.por_flag <= 1'b1;
      q.taken <= 1'b0;
    end
    else
      q <= d;
  end

  assign reset_active = (q.state != RRMC_RUN);
  assign sensitive_mode = ~q.mode_normal;
  assign por_status = q.por_flag;
  assign interrupt_request_low = ~q.por_flag;
  assign cmd_taken = q.taken;

  // helper: the soft restart command word seen while the block runs
  logic soft_seen;
  assign soft_seen = cmd_fire & is_soft;

  sequence s_soft_ok;
    soft_seen && !q.mode_normal && !q.s2[SY_RAMP] && !glitch_hit;
  endsequence

  sequence s_soft_period;
    (q.state == RRMC_SOFT) && (q.cnt == SOFT_LEN - CNT_W'(1));
  endsequence

  property p_soft_start;
    @(posedge clk_sys) disable iff (!rst_b)
    s_soft_ok |=> s_soft_period ##1 (reset_active [*3]);
  endproperty

  a_soft_restart_start: assert property (p_soft_start)
    else $error("soft restart command did not start a soft reset period");

  a_soft_normal_ignored: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    soft_seen && q.mode_normal && !q.s2[SY_RAMP] |=> q.state == RRMC_RUN)
    else $error("soft restart acted in normal mode");

  a_glitch_normal_ignored: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    q.state == RRMC_RUN && q.mode_normal && q.s2[SY_GLITCH] && !q.s2[SY_RAMP]
      && !cmd_fire |=> q.state == RRMC_RUN)
    else $error("glitch caused a reset in normal mode");

  a_glitch_sens_reset: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    q.state == RRMC_RUN && glitch_hit |=> q.state == RRMC_PWR && q.cnt == POR_LEN - CNT_W'(1))
    else $error("glitch in sensitive mode gave no power-up reset");

  a_mode_back_sensitive: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(reset_active) |-> sensitive_mode && por_status)
    else $error("reset left normal mode or no flag");

  a_no_cmd_reset: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(reset_active) && reset_active |-> !cmd_taken && !$changed(q.mode_normal))
    else $error("command accepted during reset");

  a_irq_follows_flag: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    reset_active |=> !interrupt_request_low)
    else $error("interrupt not driven after a reset");

  a_status_clears: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    cmd_fire && is_status && d.state == RRMC_RUN |=> !por_status && interrupt_request_low)
    else $error("status read did not release the interrupt");

  a_mode_write: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    cmd_fire && is_mode && d.state == RRMC_RUN |=> q.mode_normal == $past(link_word[MODE_BIT]))
    else $error("mode command bit not applied");

  a_soft_ends: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    q.state == RRMC_SOFT && q.cnt == '0 && !q.s2[SY_RAMP] && !glitch_hit
      |=> q.state == RRMC_RUN)
    else $error("soft reset did not end when its count ran out");

  // a low supply must keep the device in reset whatever state it was in
  a_ramp_holds_reset: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    q.s2[SY_RAMP] |=> reset_active)
    else $error("supply ramp did not hold the device in reset");

endmodule : rrmc_top

// ---- testbench/rrmc_mcu.sv ----
// controller model that sends serial command frames
`timescale 1ns/1ps
module rrmc_mcu
(
  output logic sck,
  output logic sel_b,
  output logic sdi
);
  // the receiver has no reset of its own: a rising select clears it
  initial
  begin
    sck = 1'b0;
    sel_b = 1'b0;
    sdi = 1'b1;
    #5 sel_b = 1'b1;
  end
  // sck stands still between frames; released sdi shows the inverse bit
  task automatic send(input logic [15:0] w);
    // odd offset keeps link edges clear of the system clock edges
    #7 sel_b = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = w[i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #120 sel_b = 1'b1;
    sdi = ~w[0];
    // one command per frame keeps load changes stepwise
    #120;
  endtask : send
endmodule : rrmc_mcu

// ---- testbench/tb.sv ----
// self-checking bench for the reset and mode control block
`timescale 1ns/1ps
module tb;
  import rrmc_pkg::*;
  localparam logic [CNT_W-1:0] P_LEN = 23'h28;
  localparam logic [CNT_W-1:0] S_LEN = 23'h0C;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ramp = 1'b0;
  logic vdd_glitch = 1'b0;
  logic sck, sel_b, sdi, reset_active, sensitive_mode, por_status;
  logic interrupt_request_low, cmd_taken;
  int fail_count = 0;
  int n_tests = 0;
  int taken_n = 0;
  int run = 0;
  int last_run = 0;
  int n_rst = 0;
  int exp_sens = 1;
  int exp_por = 1;
  always #10 clk_sys = ~clk_sys;
  rrmc_mcu mcu (.sck(sck), .sel_b(sel_b), .sdi(sdi));
  rrmc_top #(.POR_LEN(P_LEN), .SOFT_LEN(S_LEN)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .supply_ramp(supply_ramp), .vdd_glitch(vdd_glitch), .sck(sck), .sel_b(sel_b),
    .sdi(sdi), .reset_active(reset_active), .sensitive_mode(sensitive_mode),
    .por_status(por_status), .interrupt_request_low(interrupt_request_low),
    .cmd_taken(cmd_taken));
  // reset episodes and their lengths, counted on clk_sys
  always @(posedge clk_sys)
  begin
    if (cmd_taken === 1'b1)
      taken_n <= taken_n + 1;
    if (reset_active === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_run <= run;
      n_rst <= n_rst + 1;
      run <= 0;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk_state;
    chk(sensitive_mode, exp_sens);
    chk(por_status, exp_por);
    chk(interrupt_request_low, !exp_por);
  endtask : chk_state
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic settle;
    for (int i = 0; i < 300 && reset_active !== 1'b0; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk(reset_active, 1'b0);
  endtask : settle
  // lock set: frame overlaps a reset and must be dropped
  task automatic cmd(input logic [15:0] w, input int lock);
    int t0;
    int r0;
    int hit;
    t0 = taken_n;
    r0 = n_rst;
    hit = !lock && w == SOFT_RESTART_CMD && exp_sens;
    mcu.send(w);
    repeat (20) @(posedge clk_sys);
    #1;
    chk(taken_n - t0, !lock);
    // a locked frame outlasts the power-up period, which ends inside it
    chk(n_rst - r0, hit + lock);
    if (hit)
      chk(last_run, S_LEN);
    if (!lock && !w[15])
      exp_por = 0;
    if (!lock && w[15:8] == FIFO_MODE_OPCODE)
      exp_sens = !w[MODE_BIT];
    if (hit)
    begin
      exp_por = 1;
      exp_sens = 1;
    end
    chk_state();
  endtask : cmd
  task automatic pulse(input int ramp, input int len);
    int r0;
    int hit;
    r0 = n_rst;
    hit = ramp || exp_sens;
    @(posedge clk_sys);
    #1;
    if (ramp)
      supply_ramp = 1'b1;
    else
      vdd_glitch = 1'b1;
    repeat (len) @(posedge clk_sys);
    #1;
    supply_ramp = 1'b0;
    vdd_glitch = 1'b0;
    repeat (P_LEN + 20) @(posedge clk_sys);
    #1;
    chk(n_rst - r0, hit);
    if (hit && !ramp)
      chk(last_run, P_LEN);
    if (ramp)
      chk(last_run >= len, 1);
    if (hit)
    begin
      exp_por = 1;
      exp_sens = 1;
    end
    chk_state();
  endtask : pulse
  initial
  begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h4c7322d1));
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    @(posedge clk_sys);
    #1;
    chk(reset_active, 1'b1);
    chk_state();
    cmd({1'b0, 15'($urandom)}, 1);
    settle();
    cmd({1'b0, 15'($urandom)}, 0);
    cmd(16'hC001, 0);
    pulse(0, 3);
    cmd(SOFT_RESTART_CMD, 0);
    cmd(16'hC000, 0);
    cmd({1'b0, 15'($urandom)}, 0);
    cmd(SOFT_RESTART_CMD, 0);
    cmd(16'h0000, 0);
    pulse(0, 3);
    cmd(16'hC001, 0);
    pulse(1, 60);
    end_of_test();
  end
endmodule : tb
